// ---- sim/remote_serial_model.sv ----
// remote serial transceiver model: sends frames on the rx line, captures the tx line
// assumes a free-running pin clock, sixteen periods per bit
`timescale 1ns/1ps
module remote_serial_model
(
    input  logic i_pin_clk,
    input  logic i_line,
    output logic o_line
);
    initial o_line = 1'b1;
    task automatic put(input logic v);
        o_line = v;
        repeat (16) @(negedge i_pin_clk);
    endtask
    // pb below 0 sends no parity; a low stop is cut short so the line is idle before a recheck
    task automatic send(input logic [7:0] d, input int nb, input int pb, input logic stp);
        @(negedge i_pin_clk);
        put(1'b0);
        for (int i = 0; i < nb; i++)
            put(d[i]);
        if (pb >= 0)
            put(pb[0]);
        o_line = stp;
        repeat (stp ? 16 : 9) @(negedge i_pin_clk);
        o_line = 1'b1;
    endtask
    task automatic get(input int n, output logic [11:0] got);
        got = 12'h000;
        @(negedge i_line);
        repeat (8) @(posedge i_pin_clk);
        for (int i = 0; i < n; i++)
        begin
            got[i] = i_line;
            repeat (16) @(posedge i_pin_clk);
        end
    endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking bench: frame table, then error, abort and reset cases
// assumes the remote model owns the rx line and listens on the tx line
`timescale 1ns/1ps
module testbench;
    import uart_core_pkg::*;
    typedef struct packed {
        logic [7:0] d;
        logic [1:0] par;
        logic       cl;
        logic       sl;
        logic       flip;
        logic [7:0] st;
    } row_t;
    // flip sends the wrong parity bit back
    localparam row_t ROWS [7] = '{
        '{8'ha5, PAR_EVEN, 1'b1, 1'b0, 1'b0, 8'h00},
        '{8'h37, PAR_ODD, 1'b1, 1'b1, 1'b0, 8'h00},
        '{8'hff, PAR_ZERO, 1'b0, 1'b0, 1'b1, 8'h00},
        '{8'h80, PAR_NONE, 1'b0, 1'b1, 1'b0, 8'h00},
        '{8'h3c, PAR_EVEN, 1'b1, 1'b0, 1'b1, 8'h04},
        '{8'h01, PAR_ODD, 1'b0, 1'b0, 1'b1, 8'h04},
        '{8'hc9, PAR_NONE, 1'b1, 1'b1, 1'b0, 8'h00}
    };
    logic       i_mclk = 1'b0, i_rst = 1'b1, i_ext_baud_clk_pin = 1'b0, i_tx_write = 1'b0;
    logic       i_tx_enable_bit = 1'b1, i_rx_enable_bit = 1'b1, i_tx_flag_clear = 1'b0;
    logic       i_char_length_bit = 1'b1, i_stop_length_bit = 1'b0, i_rx_buffer_read = 1'b0;
    logic [1:0] i_parity_sel = PAR_EVEN;
    logic [7:0] i_baud_source_select = BAUD_SEL_EXT, i_tx_data = 8'h00, o_rx_buffer_reg, o_rx_error_status;
    logic       i_serial_rx_input, o_serial_tx_output, o_tx_busy, o_tx_complete_event;
    logic       o_tx_complete_request_flag, o_rx_complete_event, o_rx_busy;
    int         n_fail = 0, n_compared = 0, n_rx = 0, n_tx = 0;
    async_serial_uart_core u_async_serial_uart_core (.*);
    remote_serial_model u_remote_serial_model (
        .i_pin_clk (i_ext_baud_clk_pin),
        .i_line    (o_serial_tx_output),
        .o_line    (i_serial_rx_input)
    );
    always #20 i_mclk = ~i_mclk;
    // pin clock of 400 ns, phase offset from the system clock
    initial
    begin
        #7;
        forever #200 i_ext_baud_clk_pin = ~i_ext_baud_clk_pin;
    end
    always @(posedge i_mclk)
    begin
        n_rx += int'(o_rx_complete_event === 1'b1);
        n_tx += int'(o_tx_complete_event === 1'b1);
    end
    task automatic step;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
        n_compared++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_ev(input bit tx, input int k);
        for (int t = 0; t < 4000 && (tx ? n_tx : n_rx) == k; t++)
            step;
    endtask
    task automatic rx_frame(input logic [7:0] d, input int pb, input logic stp);
        int k;
        k = n_rx;
        u_remote_serial_model.send(d, i_char_length_bit ? 8 : 7, pb, stp);
        wait_ev(1'b0, k);
        chk("rx event", 12'(k + 1), 12'(n_rx));
    endtask
    task automatic rd;
        i_rx_buffer_read = 1'b1;
        step;
        i_rx_buffer_read = 1'b0;
    endtask
    initial
    begin
        #3ms;
        n_fail++;
        conclude;
    end
    initial
    begin
        row_t        r;
        logic [7:0]  dm;
        logic [11:0] got, ex;
        logic        pb;
        int          n, k, nc;
        repeat (3) step;
        i_rst = 1'b0;
        step;
        chk("status", 12'(ERR_STATUS_RST), 12'(o_rx_error_status));
        foreach (ROWS[i])
        begin
            r = ROWS[i];
            i_parity_sel = r.par;
            i_char_length_bit = r.cl;
            i_stop_length_bit = r.sl;
            dm = r.cl ? r.d : {1'b0, r.d[6:0]};
            pb = r.par == PAR_EVEN ? ^dm : r.par == PAR_ODD ? ~^dm : 1'b0;
            n = (r.cl ? 10 : 9) + int'(r.par != PAR_NONE) + int'(r.sl);
            ex = (12'h001 << n) - 12'h001;
            ex[0] = 1'b0;
            for (int b = 0; b < (r.cl ? 8 : 7); b++)
                ex[b + 1] = dm[b];
            if (r.par != PAR_NONE)
                ex[r.cl ? 9 : 8] = pb;
            i_tx_flag_clear = 1'b1;
            step;
            i_tx_flag_clear = 1'b0;
            chk("tx flag clear", 12'h000, 12'(o_tx_complete_request_flag));
            k = n_tx;
            fork
                u_remote_serial_model.get(n, got);
                begin
                    i_tx_data = r.d;
                    i_tx_write = 1'b1;
                    step;
                    i_tx_write = 1'b0;
                    nc = 0;
                    do
                    begin
                        step;
                        nc++;
                    end
                    while (o_tx_busy === 1'b1 && nc < 3000);
                end
            join
            wait_ev(1'b1, k);
            chk("tx event", 12'(k + 1), 12'(n_tx));
            // the write lands on an arbitrary tick phase, so the start bit may lose up to one tick
            chk("bit time", 12'h001, 12'(nc >= n * 160 - 10 && nc <= n * 160));
            chk("tx frame", ex, got);
            chk("tx flag", 12'h001, 12'(o_tx_complete_request_flag));
            rx_frame(r.d, r.par == PAR_NONE ? -1 : int'(pb ^ r.flip), 1'b1);
            chk("rx status", 12'(r.st), 12'(o_rx_error_status));
            chk("rx data", 12'(dm), 12'(o_rx_buffer_reg));
            rd;
            chk("status clear", 12'h000, 12'(o_rx_error_status));
        end
        i_parity_sel = PAR_EVEN;
        i_char_length_bit = 1'b1;
        rx_frame(8'h12, 0, 1'b1);
        rx_frame(8'h34, 1, 1'b1);
        chk("overrun", 12'h001, 12'(o_rx_error_status));
        chk("rx data", 12'h034, 12'(o_rx_buffer_reg));
        rd;
        rx_frame(8'h55, 0, 1'b0);
        chk("framing", 12'h002, 12'(o_rx_error_status));
        rx_frame(8'h0f, 0, 1'b1);
        chk("next frame", 12'h001, 12'(o_rx_error_status));
        rd;
        k = n_rx;
        fork
            u_remote_serial_model.send(8'hc3, 8, 0, 1'b1);
            begin
                repeat (600) step;
                chk("rx busy", 12'h001, 12'(o_rx_busy));
                i_rx_enable_bit = 1'b0;
            end
        join
        repeat (20) step;
        chk("rx idle", 12'h000, 12'(o_rx_busy));
        chk("abort event", 12'(k), 12'(n_rx));
        chk("abort data", 12'h00f, 12'(o_rx_buffer_reg));
        i_rx_enable_bit = 1'b1;
        i_rst = 1'b1;
        repeat (3) step;
        i_rst = 1'b0;
        step;
        chk("rst data", 12'(RX_BUF_RST), 12'(o_rx_buffer_reg));
        chk("rst flag", 12'h000, 12'(o_tx_complete_request_flag));
        conclude;
    end
endmodule

// ---- sim/uart_core_monitor.sv ----
// assertion checker on the serial core top ports
// assumes one clock domain; bound to every core instance
`timescale 1ns/1ps
module uart_core_monitor
    import uart_core_pkg::*;
(
    input logic       i_mclk,
    input logic       i_rst,
    input logic       i_rx_enable_bit,
    input logic [1:0] i_parity_sel,
    input logic       i_char_length_bit,
    input logic       i_rx_buffer_read,
    input logic       o_serial_tx_output,
    input logic       o_tx_busy,
    input logic       o_tx_complete_event,
    input logic       o_tx_complete_request_flag,
    input logic       o_rx_complete_event,
    input logic [7:0] o_rx_buffer_reg,
    input logic [7:0] o_rx_error_status
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    property p_rst_val; $fell(i_rst) |-> o_rx_error_status == ERR_STATUS_RST && o_rx_buffer_reg == RX_BUF_RST; endproperty
    a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
    property p_st_top; o_rx_error_status[7:3] == 5'h00; endproperty
    a_st_top: assert property (p_st_top) else $error("status upper bits set");
    property p_rx7; o_rx_complete_event && !i_char_length_bit |-> !o_rx_buffer_reg[7]; endproperty
    a_rx7: assert property (p_rx7) else $error("bit 7 set in 7-bit mode");
    property p_nopar; o_rx_complete_event && !i_parity_sel[1] |-> !o_rx_error_status[ERR_PAR_BIT]; endproperty
    a_nopar: assert property (p_nopar) else $error("parity error without check");
    property p_rd_clr; i_rx_buffer_read |=> o_rx_complete_event || o_rx_error_status == 8'h00; endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read left status set");
    property p_rx_pulse; o_rx_complete_event |=> !o_rx_complete_event; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx event too long");
    // two low cycles so a stop sample taken just before the drop may still land
    property p_abort; !i_rx_enable_bit ##1 !i_rx_enable_bit |-> !o_rx_complete_event && $stable(o_rx_buffer_reg); endproperty
    a_abort: assert property (p_abort) else $error("rx active while disabled");
    property p_tx_start; $rose(o_tx_busy) |-> !o_serial_tx_output [*8]; endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_tx_done; o_tx_complete_event |-> $past(o_tx_busy, 2) && !o_tx_busy ##[0:1] o_tx_complete_request_flag; endproperty
    a_tx_done: assert property (p_tx_done) else $error("tx complete wrong");
    property p_idle; !o_tx_busy |-> o_serial_tx_output; endproperty
    a_idle: assert property (p_idle) else $error("tx line not idle high");
    c_tx: cover property (o_tx_complete_event);
    c_par: cover property (o_rx_complete_event && o_rx_error_status[ERR_PAR_BIT]);
    c_ovr: cover property (o_rx_complete_event && o_rx_error_status[ERR_OVR_BIT]);
endmodule
bind async_serial_uart_core uart_core_monitor u_uart_core_monitor (.*);

// ---- src/async_serial_uart_core.sv ----
// async serial transceiver core: external-pin baud source, frame receiver, error status
// assumes a 25 MHz i_mclk well above 16x the bit rate; rx and baud pins are asynchronous
//
// Notes on behaviour
// - pin baud clock selected by 80H; bit rate is pin clock divided by 16.
// - frame is start, 7 or 8 data, optional parity, one or two stops.
// - seven-bit mode ignores tx bit 7 and returns rx bit 7 as zero.
// - even parity bit is data ones odd; odd parity is its inverse.
// - receiver flags parity error on odd total (even) or even total (odd).
// - zero parity sends 0 and never checks on receive.
// - no parity means no parity bit sent or expected, no parity error.
// - writing the tx shift register starts a framed transmission.
// - tx-complete event and request flag rise once the shift register empties.
// - receive enable makes the receiver sample the rx line on the bit clock.
// - falling line starts 3-bit counter; half-bit recheck confirms start bit.
// - frame ends after data, optional parity and one stop bit only.
// - completed frame moves to receive buffer and raises rx-complete event.
// - faulty frames still load the buffer and raise rx-complete.
// - dropping receive enable aborts reception; buffer and status kept, no event.
// - parity, framing and overrun errors are detected.
// - parity error alone reads error status 04H.
// - buffer read or next frame clears error flags; new faults set again.
// - parity field 00 none, 01 zero, 10 odd, 11 even.
// - char length 0 is 7 bits, 1 is 8; stop length 0 one, 1 two.
// - error status bit2 parity, bit1 framing, bit0 overrun; resets 00H.
// - select bits 1000 choose the pin clock; other values prohibited.
`timescale 1ns/1ps
module async_serial_uart_core
    import uart_core_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_ext_baud_clk_pin,
    input  wire logic [7:0] i_baud_source_select,
    input  wire logic       i_tx_enable_bit,
    input  wire logic       i_rx_enable_bit,
    input  wire logic [1:0] i_parity_sel,
    input  wire logic       i_char_length_bit,
    input  wire logic       i_stop_length_bit,
    input  wire logic       i_tx_write,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_rx_buffer_read,
    input  wire logic       i_tx_flag_clear,
    input  wire logic       i_serial_rx_input,
    output logic            o_serial_tx_output,
    output logic            o_tx_busy,
    output logic            o_tx_complete_event,
    output logic            o_tx_complete_request_flag,
    output logic            o_rx_complete_event,
    output logic [7:0]      o_rx_buffer_reg,
    output logic [7:0]      o_rx_error_status,
    output logic            o_rx_busy
);
    import uart_core_pkg::*;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

    baud_tick_if bt ();

    logic [2:0] bclk_sync_r;
    logic [1:0] rxd_sync_r;
    logic       rxd_s;
    logic       src_ok;
    rx_state_t  state_r;
    logic [3:0] sub_r;
    logic [2:0] half_cnt_r;
    logic [2:0] bit_idx_r;
    logic [7:0] shift_r;
    logic       par_err_r;
    logic       rx_done_pulse;
    logic       rx_full_r;
    logic [7:0] char_nxt;
    logic       tx_done;

    // pin clock crosses two flops; the third only feeds the edge detector
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            bclk_sync_r <= '0;
        else
            bclk_sync_r <= {bclk_sync_r[1:0], i_ext_baud_clk_pin};
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            rxd_sync_r <= 2'b11;
        else
            rxd_sync_r <= {rxd_sync_r[0], i_serial_rx_input};
    end
    assign rxd_s = rxd_sync_r[1];

    // prohibited select codes freeze the bit clock instead of running at a guess
    assign src_ok        = i_baud_source_select == BAUD_SEL_EXT
                           && i_baud_source_select[7:4] == BAUD_SRC_EXT;
    assign bt.tick16     = src_ok && bclk_sync_r[1] && !bclk_sync_r[2];
    assign bt.cfg        = '{parity_sel: i_parity_sel, char_length_bit: i_char_length_bit,
                             stop_length_bit: i_stop_length_bit};

    uart_tx u_tx (
        .i_mclk          (i_mclk),
        .i_rst           (i_rst),
        .bt              (bt.dst),
        .i_tx_enable_bit (i_tx_enable_bit),
        .i_tx_write      (i_tx_write),
        .i_tx_data       (i_tx_data),
        .o_txd           (o_serial_tx_output),
        .o_tx_busy       (o_tx_busy),
        .o_tx_done       (tx_done)
    );

    assign o_tx_complete_event = tx_done;

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_tx_complete_request_flag <= 1'b0;
        else if (tx_done)
            o_tx_complete_request_flag <= 1'b1;
        else if (i_tx_flag_clear)
            o_tx_complete_request_flag <= 1'b0;
    end

    // receive sequencer; sub_r counts 16x ticks within a bit
    always_ff @(posedge i_mclk)
    begin
        if (i_rst || !i_rx_enable_bit)
        begin
            state_r    <= RX_IDLE;
            sub_r      <= '0;
            half_cnt_r <= '0;
            bit_idx_r  <= '0;
            shift_r    <= '0;
        end
        else if (bt.tick16)
        begin
            unique case (state_r)
                RX_IDLE:
                begin
                    half_cnt_r <= '0;
                    if (!rxd_s)
                        state_r <= RX_START;
                end
                RX_START:
                begin
                    half_cnt_r <= half_cnt_r + 3'd1;
                    if (half_cnt_r == 3'(START_HALF - 2))
                    begin
                        // half a bit after the fall: recheck the line
                        if (!rxd_s)
                        begin
                            state_r   <= RX_DATA;
                            sub_r     <= '0;
                            bit_idx_r <= '0;
                        end
                        else
                            state_r <= RX_IDLE;
                    end
                end
                default:
                begin
                    sub_r <= sub_r + 4'd1;
                    if (sub_r == 4'(BAUD_DIV - 1))
                    begin
                        sub_r <= '0;
                        if (state_r == RX_DATA)
                        begin
                            shift_r   <= {rxd_s, shift_r[7:1]};
                            bit_idx_r <= bit_idx_r + 3'd1;
                            if (bit_idx_r == (i_char_length_bit ? 3'd7 : 3'd6))
                                state_r <= (i_parity_sel == PAR_NONE) ? RX_STOP : RX_PARITY;
                        end
                        else if (state_r == RX_PARITY)
                            state_r <= RX_STOP;
                        else
                            state_r <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // 7-bit characters land in shift_r[7:1]; realign and zero bit 7
    assign char_nxt = i_char_length_bit ? shift_r : {1'b0, shift_r[7:1]};

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || !i_rx_enable_bit)
            par_err_r <= 1'b0;
        else if (bt.tick16 && state_r == RX_PARITY && sub_r == 4'(BAUD_DIV - 1))
        begin
            unique case (i_parity_sel)
                PAR_EVEN: par_err_r <= odd_ones(char_nxt) ^ rxd_s;
                PAR_ODD:  par_err_r <= ~(odd_ones(char_nxt) ^ rxd_s);
                default:  par_err_r <= 1'b0;
            endcase
        end
        else if (state_r == RX_IDLE)
            par_err_r <= 1'b0;
    end

    assign rx_done_pulse = i_rx_enable_bit && bt.tick16 && state_r == RX_STOP
                           && sub_r == 4'(BAUD_DIV - 1);

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_rx_buffer_reg     <= RX_BUF_RST;
            o_rx_error_status   <= ERR_STATUS_RST;
            o_rx_complete_event <= 1'b0;
            rx_full_r           <= 1'b0;
        end
        else
        begin
            o_rx_complete_event <= rx_done_pulse;
            if (rx_done_pulse)
            begin
                o_rx_buffer_reg                <= char_nxt;
                rx_full_r                      <= 1'b1;
                // new frame replaces all flags, which wins over a same-cycle read
                o_rx_error_status              <= ERR_STATUS_RST;
                o_rx_error_status[ERR_PAR_BIT] <= par_err_r;
                o_rx_error_status[ERR_FRM_BIT] <= !rxd_s;
                o_rx_error_status[ERR_OVR_BIT] <= rx_full_r && !i_rx_buffer_read;
            end
            else if (i_rx_buffer_read)
            begin
                rx_full_r         <= 1'b0;
                o_rx_error_status <= ERR_STATUS_RST;
            end
        end
    end

    assign o_rx_busy = state_r != RX_IDLE;
endmodule

// ---- src/baud_tick_if.sv ----
// carries the 16x sample tick from the core to its tx and rx halves, and the frame settings to its tx half
// assumes all members are driven in the i_mclk domain
`timescale 1ns/1ps
interface baud_tick_if;
    import uart_core_pkg::*;
    logic       tick16;
    frame_cfg_t cfg;
    modport src (output tick16, output cfg);
    modport dst (input tick16, input cfg);
endinterface

// ---- src/uart_core_pkg.sv ----
// constants shared by the async serial core and its sub-blocks
// assumes a single system clock domain; no bus, configuration arrives on plain ports
package uart_core_pkg;
    localparam int          BAUD_DIV        = 16;
    localparam int          START_HALF      = 8;
    localparam logic [3:0]  BAUD_SRC_EXT    = 4'h8;
    localparam logic [7:0]  BAUD_SEL_EXT    = 8'h80;
    localparam logic [1:0]  PAR_NONE        = 2'h0;
    localparam logic [1:0]  PAR_ZERO        = 2'h1;
    localparam logic [1:0]  PAR_ODD         = 2'h2;
    localparam logic [1:0]  PAR_EVEN        = 2'h3;
    localparam int          ERR_PAR_BIT     = 2;
    localparam int          ERR_FRM_BIT     = 1;
    localparam int          ERR_OVR_BIT     = 0;
    localparam logic [7:0]  ERR_STATUS_RST  = 8'h00;
    localparam logic [7:0]  RX_BUF_RST      = 8'h00;
    localparam logic [10:0] TX_SHIFT_IDLE   = 11'h7ff;

    typedef struct packed {
        logic [1:0] parity_sel;
        logic       char_length_bit;
        logic       stop_length_bit;
    } frame_cfg_t;

    function automatic logic odd_ones(input logic [7:0] d);
        return ^d;
    endfunction
endpackage

// ---- src/uart_tx.sv ----
// transmit half: frames a character and shifts it out lsb first
// assumes tick16 is a one-cycle pulse at sixteen times the bit rate
`timescale 1ns/1ps
module uart_tx
    import uart_core_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    baud_tick_if.dst        bt,
    input  wire logic       i_tx_enable_bit,
    input  wire logic       i_tx_write,
    input  wire logic [7:0] i_tx_data,
    output logic            o_txd,
    output logic            o_tx_busy,
    output logic            o_tx_done
);
    import uart_core_pkg::*;

    logic [10:0] shift_r;
    logic [3:0]  bits_left_r;
    logic [3:0]  sub_r;
    logic        busy_r;
    logic [7:0]  data_nxt;
    logic        par_nxt;
    logic [3:0]  count_nxt;
    logic [10:0] frame_nxt;

    always_comb
    begin
        data_nxt  = bt.cfg.char_length_bit ? i_tx_data : {1'b0, i_tx_data[6:0]};
        par_nxt   = 1'b0;
        unique case (bt.cfg.parity_sel)
            PAR_EVEN: par_nxt = odd_ones(data_nxt);
            PAR_ODD:  par_nxt = ~odd_ones(data_nxt);
            default:  par_nxt = 1'b0;
        endcase
        // bits after the start bit: data, optional parity, stops
        count_nxt = 4'd7 + {3'd0, bt.cfg.char_length_bit} + {3'd0, bt.cfg.parity_sel != PAR_NONE}
                  + 4'd1 + {3'd0, bt.cfg.stop_length_bit};
        // positions above the character keep the idle ones, which become the stop bits
        frame_nxt = TX_SHIFT_IDLE;
        if (bt.cfg.parity_sel == PAR_NONE)
        begin
            if (bt.cfg.char_length_bit)
                frame_nxt[7:0] = data_nxt;
            else
                frame_nxt[6:0] = data_nxt[6:0];
        end
        else if (bt.cfg.char_length_bit)
            frame_nxt[8:0] = {par_nxt, data_nxt};
        else
            frame_nxt[7:0] = {par_nxt, data_nxt[6:0]};
        frame_nxt = {frame_nxt[9:0], 1'b0};
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || !i_tx_enable_bit)
        begin
            shift_r     <= TX_SHIFT_IDLE;
            bits_left_r <= '0;
            sub_r       <= '0;
            busy_r      <= 1'b0;
        end
        else if (i_tx_write && !busy_r)
        begin
            shift_r     <= frame_nxt;
            bits_left_r <= count_nxt + 4'd1;
            sub_r       <= '0;
            busy_r      <= 1'b1;
        end
        else if (busy_r && bt.tick16)
        begin
            sub_r <= sub_r + 4'd1;
            if (sub_r == 4'(BAUD_DIV - 1))
            begin
                shift_r     <= {1'b1, shift_r[10:1]};
                bits_left_r <= bits_left_r - 4'd1;
                if (bits_left_r == 4'd1)
                    busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_tx_done <= 1'b0;
        else
            o_tx_done <= i_tx_enable_bit && busy_r && bt.tick16 && sub_r == 4'(BAUD_DIV - 1)
                         && bits_left_r == 4'd1;
    end

    assign o_txd     = busy_r ? shift_r[0] : 1'b1;
    assign o_tx_busy = busy_r;
endmodule
